/* bench/testbench.sv */
// Self-checking bench for the block write command core
`timescale 1ns/10ps
module testbench import wmb_pkg::*; ;
  logic i_core_clk, i_rst_n, i_reg_wr, i_reg_rd, o_iordy, o_intrq;
  logic o_media_valid, i_media_ready, stall;
  logic [3:0] i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata, o_media_data, q;
  logic [7:0] i_multi_size;
  logic [47:0] i_capacity;
  int err_count, num_checks, tx_cnt, rx_cnt, cyc;

  wmb_core dut (.i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
    .o_reg_rdata, .o_iordy, .o_intrq, .i_multi_size, .i_capacity, .o_media_data,
    .o_media_valid, .i_media_ready);
  wmb_host host (.i_core_clk, .i_rdata(o_reg_rdata), .i_iordy(o_iordy), .o_addr(i_reg_addr),
    .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_wdata(i_reg_wdata));

  // Clock and time-zero values
  initial begin
    {i_rst_n, i_media_ready, stall} = 3'h4;
    {err_count, num_checks, tx_cnt, rx_cnt, cyc} = '0;
    i_multi_size = 8'h02;
    i_capacity = 48'h0000_0F00_0000;
    i_core_clk = 1'b0;
    #5 i_rst_n = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    host.rd(a, q);
    check(q, e);
  endtask
  task automatic sec_send(input int n);
    repeat (n) begin
      host.dwr(16'h3C00 + 16'(tx_cnt));
      tx_cnt++;
    end
  endtask
  task automatic irq_wait;
    int k;
    k = 0;
    while (o_intrq !== 1'b1 && k < 6000) begin
      @(posedge i_core_clk);
      k++;
    end
    check({15'h0, o_intrq}, 16'h0001);
  endtask
  task automatic wrap_up;
    $display("checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Media sink, stalling when asked, words checked in order
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    i_media_ready <= !stall || (cyc[5:4] == 2'b11);
    if (i_rst_n && o_media_valid && i_media_ready) begin
      check(o_media_data, 16'h3C00 + 16'(rx_cnt));
      rx_cnt++;
    end
  end

  // Watchdog
  initial begin
    #800000;
    err_count++;
    wrap_up();
  end

  // Test sequence
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    rchk(RA_CMD, 16'h0050);
    rchk(4'hC, 16'h0000);
    host.wr(RA_CNT, 8'h12);
    host.wr(RA_CNT, 8'h34);
    rchk(RA_CNT, 16'h0034);
    host.wr(RA_CTL, 8'h80);
    rchk(RA_CNT, 16'h0012);
    // Unknown opcode, then a zero block setting
    for (int i = 0; i < 2; i++) begin
      @(posedge i_core_clk);
      i_multi_size <= (i == 0) ? 8'h02 : 8'h00;
      host.wr(RA_CMD, (i == 0) ? 8'hEE : OP_WMUL);
      @(posedge i_core_clk);
      #1;
      check({15'h0, o_intrq}, 16'h0001);
      rchk(RA_FEAT, 16'h0004);
      rchk(RA_CMD, 16'h0051);
      check({15'h0, o_intrq}, 16'h0000);
    end
    // Three sectors in blocks of two, media stalling, address carry
    @(posedge i_core_clk);
    i_multi_size <= 8'h02;
    stall <= 1'b1;
    host.wr(RA_CNT, 8'h03);
    host.wr(RA_SN, 8'hFE);
    host.wr(RA_CL, 8'hCD);
    host.wr(RA_CH, 8'hAB);
    host.wr(RA_DH, 8'h43);
    host.wr(RA_CMD, OP_WMUL);
    rchk(RA_CMD, 16'h0058);
    sec_send(256);
    check({15'h0, o_intrq}, 16'h0000);
    sec_send(256);
    irq_wait();
    rchk(RA_CMD, 16'h0058);
    sec_send(256);
    irq_wait();
    rchk(RA_CMD, 16'h0050);
    rchk(RA_CNT, 16'h0000);
    rchk(RA_SN, 16'h0000);
    rchk(RA_CL, 16'h00CE);
    rchk(RA_CH, 16'h00AB);
    host.rd(RA_DH, q);
    check({12'h000, q[3:0]}, 16'h0003);
    rchk(RA_DATA, 16'h0000);
    // Geometric mode, two sectors wrapping sector, head and cylinder
    @(posedge i_core_clk);
    stall <= 1'b0;
    i_multi_size <= 8'h08;
    host.wr(RA_CNT, 8'h02);
    host.wr(RA_SN, 8'h3F);
    host.wr(RA_CL, 8'h10);
    host.wr(RA_CH, 8'h00);
    host.wr(RA_DH, 8'hAF);
    host.wr(RA_CMD, OP_WMUL);
    sec_send(512);
    irq_wait();
    rchk(RA_CMD, 16'h0050);
    rchk(RA_CNT, 16'h0000);
    rchk(RA_SN, 16'h0001);
    rchk(RA_CL, 16'h0011);
    rchk(RA_CH, 16'h0000);
    rchk(RA_DH, 16'h00A0);
    // Zero count from the last sector: second sector is out of range
    @(posedge i_core_clk);
    stall <= 1'b0;
    i_multi_size <= 8'h08;
    host.wr(RA_CNT, 8'h00);
    host.wr(RA_SN, 8'hFF);
    host.wr(RA_CL, 8'hFF);
    host.wr(RA_CH, 8'hFF);
    host.wr(RA_DH, 8'h4E);
    host.wr(RA_CMD, OP_WMUL);
    sec_send(257);
    irq_wait();
    rchk(RA_FEAT, 16'h0010);
    rchk(RA_CMD, 16'h0051);
    rchk(RA_CNT, 16'h00FF);
    rchk(RA_SN, 16'h0000);
    rchk(RA_CH, 16'h0000);
    // Extended form with a first sector beyond capacity
    host.wr(RA_CNT, 8'h00);
    host.wr(RA_CNT, 8'h01);
    for (int i = 0; i < 3; i++) begin
      host.wr(4'(RA_SN + i), 8'(3 - i));
      host.wr(4'(RA_SN + i), 8'(6 - i));
    end
    host.wr(RA_DH, 8'h40);
    host.wr(RA_CMD, OP_WMUL_EXT);
    irq_wait();
    rchk(RA_FEAT, 16'h0010);
    for (int i = 0; i < 3; i++) begin
      rchk(4'(RA_SN + i), 16'(6 - i));
    end
    host.wr(RA_CTL, 8'h80);
    for (int i = 0; i < 3; i++) begin
      rchk(4'(RA_SN + i), 16'(3 - i));
    end
    wrap_up();
  end
endmodule // testbench

/* bench/wmb_core_assertions.sv */
// Port-level checks for the block write command core
`timescale 1ns/10ps
module wmb_chk import wmb_pkg::*; (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Register bus
  input wire logic [3:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_iordy,
  input wire logic o_intrq,
  // Media stream
  input wire logic [15:0] o_media_data,
  input wire logic o_media_valid,
  input wire logic i_media_ready
);
  // Status read and command write strobes
  wire rd_stat = i_reg_rd && (i_reg_addr == RA_CMD);
  wire wr_cmd = i_reg_wr && (i_reg_addr == RA_CMD);

  rst_quiet_a: assert property (@(posedge i_core_clk)
    !i_rst_n |-> !o_iordy && !o_intrq && !o_media_valid) else $error("active in reset");
  ready_wake_a: assert property (@(posedge i_core_clk)
    $rose(i_rst_n) |=> o_iordy) else $error("no ready after reset");
  media_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_media_valid && !i_media_ready |=> o_media_valid && $stable(o_media_data))
    else $error("media word dropped");
  upper_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_reg_rdata[15:8] == 8'h00) else $error("upper byte set");
  data_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == RA_DATA |=> o_reg_rdata == 16'h0000)
    else $error("data read not zero");
  rdata_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");
  stat_fixed_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    rd_stat |=> o_reg_rdata[ST_RDY] && o_reg_rdata[ST_DSC]
      && !(o_reg_rdata[ST_BSY] && o_reg_rdata[ST_DRQ]))
    else $error("status bits wrong");
  unmapped_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr > RA_CTL |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  irq_sticky_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_intrq && !rd_stat && !wr_cmd |=> o_intrq) else $error("interrupt lost");
  irq_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_intrq && rd_stat |=> !o_intrq || o_reg_rdata[ST_BSY])
    else $error("interrupt not cleared");
endmodule // wmb_chk

bind wmb_core wmb_chk u_chk (.i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wr, .i_reg_rd,
  .o_reg_rdata, .o_iordy, .o_intrq, .o_media_data, .o_media_valid, .i_media_ready);

/* bench/wmb_host.sv */
// Host adapter model driving the command block registers
`timescale 1ns/10ps
module wmb_host import wmb_pkg::*; (
  // Clock and device answers
  input wire logic i_core_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_iordy,
  // Register access
  output logic [3:0] o_addr = 4'h0,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [15:0] o_wdata = 16'h0000
);
  // One access held for one edge, lines scrambled once released
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= !w;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'b1, a, {8'h00, d});
  endtask
  // Read, data taken the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    acc(1'b0, a, 16'h0000);
    #1;
    q = i_rdata;
  endtask
  // Data word only while the device can take it
  task automatic dwr(input logic [15:0] d);
    @(posedge i_core_clk);
    #1;
    while (i_iordy !== 1'b1) begin
      @(posedge i_core_clk);
      #1;
    end
    acc(1'b1, RA_DATA, d);
  endtask
endmodule // wmb_host

/* core/wmb_core.sv */
// Device-side multi-sector block write command interpreter
// How it works
// - Opcode C5h starts the 28-bit block multi-sector write.
// - Payload words flow in, then drain to the media before completion.
// - One interrupt per block of sectors sized by the multiple setting.
// - Each data register write carries one 16-bit payload word.
// - Count register gives sectors to move; zero means 256.
// - Logical mode: address bytes 0,1,2 give address bits 0-23.
// - Logical mode: head field gives address bits 24-27.
// - Mode bit clear: sector, cylinder and head are geometric.
// - At completion the count register holds sectors not moved.
// - At completion address fields hold the last sector moved.
// - Opcode 39h starts the 48-bit variant with two-byte registers.
// - In the 48-bit variant a zero count means 65,536 sectors.
// - After an error the failing 48-bit address reads back by half.
`timescale 1ns/10ps
module wmb_core import wmb_pkg::*; (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Host command block access
  input wire logic [3:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_iordy,
  output logic o_intrq,
  // Drive configuration
  input wire logic [7:0] i_multi_size,
  input wire logic [47:0] i_capacity,
  // Media side
  output logic [15:0] o_media_data,
  output logic o_media_valid,
  input wire logic i_media_ready
);
  wmb_state_t state_ff, nxt_state;
  wmb_tf_t tf_ff, nxt_tf;
  logic ext_ff, nxt_ext;
  logic [7:0] err_ff, nxt_err;
  logic [16:0] rem_ff, nxt_rem;
  logic [7:0] word_ff, nxt_word;
  logic [7:0] blk_ff, nxt_blk;
  logic irq_ff, nxt_irq;
  logic hob_ff, nxt_hob;
  logic [15:0] rdata_ff;
  logic iordy_ff;
  logic [15:0] mdata_ff;
  logic mvalid_ff;
  logic [7:0] status_w;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic [3:0] fifo_cnt;

  // Address match
  // Shared by every register strobe and the read selector
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ra);
    return a == ra;
  endfunction

  // Byte half chosen by the high-order byte select
  function automatic logic [7:0] half(input logic [15:0] v, input logic high_order_byte_select);
    return high_order_byte_select ? v[15:8] : v[7:0];
  endfunction

  // Logical address gathered from the command block
  function automatic logic [47:0] lba_of(input wmb_tf_t t, input logic ext);
    if (ext) begin
      return {t.ch[15:8], t.cl[15:8], t.sn[15:8], t.ch[7:0], t.cl[7:0], t.sn[7:0]};
    end
    return {20'h00000, t.dh[3:0], t.ch[7:0], t.cl[7:0], t.sn[7:0]};
  endfunction

  // Logical address scattered back into the command block
  function automatic wmb_tf_t put_lba(input wmb_tf_t t, input logic [47:0] l, input logic ext);
    wmb_tf_t r;
    r = t;
    r.sn[7:0] = l[7:0];
    r.cl[7:0] = l[15:8];
    r.ch[7:0] = l[23:16];
    if (ext) begin
      r.sn[15:8] = l[31:24];
      r.cl[15:8] = l[39:32];
      r.ch[15:8] = l[47:40];
    end else begin
      r.dh[3:0] = l[27:24];
    end
    return r;
  endfunction

  // Address of the following sector
  // Geometric stepping wraps sector to one, then head, then cylinder
  function automatic wmb_tf_t adv(input wmb_tf_t t, input logic ext);
    wmb_tf_t r;
    logic [15:0] cyl;
    r = t;
    cyl = {t.ch[7:0], t.cl[7:0]};
    if (ext || t.dh[DH_LBA]) begin
      r = put_lba(t, lba_of(t, ext) + 48'h1, ext);
    end else if (t.sn[7:0] == GEO_SPT) begin
      r.sn[7:0] = GEO_FIRST_SEC;
      if (t.dh[3:0] == GEO_HEAD_MAX) begin
        r.dh[3:0] = 4'h0;
        cyl = cyl + 16'h1;
      end else begin
        r.dh[3:0] = t.dh[3:0] + 4'h1;
      end
      r.cl[7:0] = cyl[7:0];
      r.ch[7:0] = cyl[15:8];
    end else begin
      r.sn[7:0] = t.sn[7:0] + 8'h1;
    end
    return r;
  endfunction

  // Target sector exists on the drive
  // Checked on the first word of each sector, so a bad target drops
  // the word instead of letting it reach the media
  function automatic logic addr_ok(input wmb_tf_t t, input logic ext, input logic [47:0] cap);
    logic [47:0] chs;
    chs = ({32'h0000_0000, t.ch[7:0], t.cl[7:0]} * GEO_HEADS_W + {44'h0, t.dh[3:0]}) * GEO_SPT_W
      + {40'h0, t.sn[7:0]} - 48'h1;
    if (ext || t.dh[DH_LBA]) begin
      return lba_of(t, ext) < cap;
    end
    return (t.sn[7:0] != 8'h00) && (t.sn[7:0] <= GEO_SPT) && (chs < cap);
  endfunction

  // Access decode
  // Outside the idle state, writes change only the interrupt, the byte select and, during transfer, the data words taken
  wire wr_data = i_reg_wr && hit(i_reg_addr, RA_DATA);
  wire wr_cnt = i_reg_wr && hit(i_reg_addr, RA_CNT);
  wire wr_sn = i_reg_wr && hit(i_reg_addr, RA_SN);
  wire wr_cl = i_reg_wr && hit(i_reg_addr, RA_CL);
  wire wr_ch = i_reg_wr && hit(i_reg_addr, RA_CH);
  wire wr_dh = i_reg_wr && hit(i_reg_addr, RA_DH);
  wire wr_cmd = i_reg_wr && hit(i_reg_addr, RA_CMD);
  wire wr_ctl = i_reg_wr && hit(i_reg_addr, RA_CTL);
  wire wr_tf = wr_cnt || wr_sn || wr_cl || wr_ch || wr_dh;
  wire rd_status = i_reg_rd && hit(i_reg_addr, RA_CMD);

  // Command decode
  wire [7:0] op = i_reg_wdata[7:0];
  wire cmd_ext = (op == OP_WMUL_EXT);
  wire cmd_ours = ((op == OP_WMUL) || cmd_ext) && (i_multi_size != 8'h00);
  wire start_ok = addr_ok(tf_ff, cmd_ext, i_capacity);
  wire cur_ok = addr_ok(tf_ff, ext_ff, i_capacity);
  wire [16:0] rem28 = (tf_ff.cnt[7:0] == 8'h00) ? CNT28_ZERO : {9'h000, tf_ff.cnt[7:0]};
  wire [16:0] rem48 = (tf_ff.cnt == 16'h0000) ? CNT48_ZERO : {1'b0, tf_ff.cnt};
  wire [16:0] init_rem = cmd_ext ? rem48 : rem28;
  wire [16:0] rem_dec = rem_ff - 17'h00001;
  wire [7:0] blk_inc = blk_ff + 8'h01;

  // Word acceptance, gated by the buffer
  // Ready flag is one cycle old; one slot of headroom covers it
  wire word_slot = wr_data && (state_ff == S_XFER) && iordy_ff && fifo_in_ready;
  wire take_word = word_slot && ((word_ff != 8'h00) || cur_ok);
  wire bad_first = word_slot && (word_ff == 8'h00) && !cur_ok;
  wire sec_done = take_word && (word_ff == SEC_LAST_WORD);
  wire drained = (fifo_cnt == 4'h0) && !mvalid_ff;
  wire fifo_out_ready = !mvalid_ff || i_media_ready;
  wire clr_irq = rd_status || wr_cmd;

  // Status byte
  // Busy only while a block drains, never together with request
  always_comb begin
    status_w = 8'h00;
    status_w[ST_BSY] = (state_ff == S_DRAIN);
    status_w[ST_RDY] = 1'b1;
    status_w[ST_DSC] = 1'b1;
    status_w[ST_DRQ] = (state_ff == S_XFER);
    status_w[ST_ERR] = (err_ff != 8'h00);
  end

  // Read selection
  // Data register reads return zero; payload only flows inward
  // half by select bit
  wire [15:0] rd_mux =
    hit(i_reg_addr, RA_FEAT) ? {8'h00, err_ff} :
    hit(i_reg_addr, RA_CNT) ? {8'h00, half(tf_ff.cnt, hob_ff)} :
    hit(i_reg_addr, RA_SN) ? {8'h00, half(tf_ff.sn, hob_ff)} :
    hit(i_reg_addr, RA_CL) ? {8'h00, half(tf_ff.cl, hob_ff)} :
    hit(i_reg_addr, RA_CH) ? {8'h00, half(tf_ff.ch, hob_ff)} :
    hit(i_reg_addr, RA_DH) ? {8'h00, tf_ff.dh} :
    (hit(i_reg_addr, RA_CMD) || hit(i_reg_addr, RA_CTL)) ? {8'h00, status_w} : 16'h0000;

  // Command sequencer
  // An interrupt set after its clear wins within the same cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_tf = tf_ff;
    nxt_ext = ext_ff;
    nxt_err = err_ff;
    nxt_rem = rem_ff;
    nxt_word = word_ff;
    nxt_blk = blk_ff;
    nxt_irq = irq_ff;
    nxt_hob = hob_ff;
    if (clr_irq) nxt_irq = 1'b0;
    if (wr_ctl) nxt_hob = i_reg_wdata[CTL_HOB];
    if (wr_tf) nxt_hob = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (wr_cnt) nxt_tf.cnt = {tf_ff.cnt[7:0], i_reg_wdata[7:0]};
        if (wr_sn) nxt_tf.sn = {tf_ff.sn[7:0], i_reg_wdata[7:0]};
        if (wr_cl) nxt_tf.cl = {tf_ff.cl[7:0], i_reg_wdata[7:0]};
        if (wr_ch) nxt_tf.ch = {tf_ff.ch[7:0], i_reg_wdata[7:0]};
        if (wr_dh) nxt_tf.dh = i_reg_wdata[7:0];
        if (wr_cmd) begin
          nxt_err = 8'h00;
          if (!cmd_ours) begin
            nxt_err[ER_ABT] = 1'b1;
            nxt_irq = 1'b1;
          end else if (!start_ok) begin
            nxt_err[ER_IDN] = 1'b1;
            nxt_irq = 1'b1;
          end else begin
            nxt_ext = cmd_ext;
            nxt_rem = init_rem;
            nxt_word = 8'h00;
            nxt_blk = 8'h00;
            nxt_state = S_XFER;
          end
        end
      end
      S_XFER: begin
        if (take_word) nxt_word = word_ff + 8'h01;
        if (sec_done) begin
          nxt_rem = rem_dec;
          nxt_blk = blk_inc;
          if (rem_dec != 17'h00000) nxt_tf = adv(tf_ff, ext_ff);
          nxt_tf.cnt = rem_dec[15:0];
          if ((rem_dec == 17'h00000) || (blk_inc == i_multi_size)) nxt_state = S_DRAIN;
        end else if (bad_first) begin
          nxt_err[ER_IDN] = 1'b1;
          nxt_irq = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      S_DRAIN: begin
        if (drained) begin
          nxt_irq = 1'b1;
          nxt_blk = 8'h00;
          if (rem_ff == 17'h00000) begin
            nxt_state = S_IDLE;
          end else if (cur_ok) begin
            nxt_state = S_XFER;
          end else begin
            nxt_err[ER_IDN] = 1'b1;
            nxt_state = S_IDLE;
          end
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // Sequencer registers
  // Whole command block cleared, so the mode bit starts at zero
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= S_IDLE;
      tf_ff <= '0;
      ext_ff <= 1'b0;
      err_ff <= 8'h00;
      rem_ff <= 17'h00000;
      word_ff <= 8'h00;
      blk_ff <= 8'h00;
      irq_ff <= 1'b0;
      hob_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tf_ff <= nxt_tf;
      ext_ff <= nxt_ext;
      err_ff <= nxt_err;
      rem_ff <= nxt_rem;
      word_ff <= nxt_word;
      blk_ff <= nxt_blk;
      irq_ff <= nxt_irq;
      hob_ff <= nxt_hob;
    end
  end

  // Read data, ready and media stage
  // Media stage holds its word while the sink stalls
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= 16'h0000;
      iordy_ff <= 1'b0;
      mdata_ff <= 16'h0000;
      mvalid_ff <= 1'b0;
    end else begin
      if (i_reg_rd) rdata_ff <= rd_mux;
      iordy_ff <= (fifo_cnt < FIFO_IORDY_LIM);
      if (fifo_out_ready) begin
        mvalid_ff <= fifo_out_valid;
        mdata_ff <= fifo_out_data;
      end
    end
  end

  wmb_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(take_word),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_reg_wdata),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data),
    .o_count(fifo_cnt)
  );

  // Outputs
  // Every output is a register, so the host sees no decode glitches
  assign o_reg_rdata = rdata_ff;
  assign o_iordy = iordy_ff;
  assign o_intrq = irq_ff;
  assign o_media_data = mdata_ff;
  assign o_media_valid = mvalid_ff;
endmodule // wmb_core

/* core/wmb_fifo.sv */
// Payload word FIFO between the data register and the media side
`timescale 1ns/10ps
module wmb_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  // Fill level
  output logic [$clog2(D):0] o_count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0] cnt_ff;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  // Flags from the occupancy count
  assign o_in_ready = (cnt_ff != (AW+1)'(D));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem[rptr_ff];
  assign o_count = cnt_ff;

  // Storage write
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wptr_ff] <= i_in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wptr_ff <= wptr_ff + 1'b1;
      if (pop) rptr_ff <= rptr_ff + 1'b1;
      if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule // wmb_fifo

/* core/wmb_pkg.sv */
// Constants and types for the multi-sector block write command block
package wmb_pkg;
  // Command block register addresses
  localparam logic [3:0] RA_DATA = 4'h0;
  localparam logic [3:0] RA_FEAT = 4'h1;
  localparam logic [3:0] RA_CNT = 4'h2;
  localparam logic [3:0] RA_SN = 4'h3;
  localparam logic [3:0] RA_CL = 4'h4;
  localparam logic [3:0] RA_CH = 4'h5;
  localparam logic [3:0] RA_DH = 4'h6;
  localparam logic [3:0] RA_CMD = 4'h7;
  localparam logic [3:0] RA_CTL = 4'h8;
  // Opcodes
  localparam logic [7:0] OP_WMUL = 8'hC5;
  localparam logic [7:0] OP_WMUL_EXT = 8'h39;
  // Counts
  localparam logic [7:0] SEC_LAST_WORD = 8'hFF;
  localparam logic [16:0] CNT28_ZERO = 17'h00100;
  localparam logic [16:0] CNT48_ZERO = 17'h10000;
  // Field positions
  localparam int DH_LBA = 6;
  localparam int CTL_HOB = 7;
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_IDN = 4;
  localparam int ER_ABT = 2;
  // Geometry for geometric mode
  localparam logic [7:0] GEO_SPT = 8'h3F;
  localparam logic [7:0] GEO_FIRST_SEC = 8'h01;
  localparam logic [3:0] GEO_HEAD_MAX = 4'hF;
  localparam logic [47:0] GEO_HEADS_W = 48'h0000_0000_0010;
  localparam logic [47:0] GEO_SPT_W = 48'h0000_0000_003F;
  // Buffer shape
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 8;
  localparam logic [3:0] FIFO_IORDY_LIM = 4'h7;

  // Command block contents, previous byte in [15:8]
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] sn;
    logic [15:0] cl;
    logic [15:0] ch;
    logic [7:0] dh;
  } wmb_tf_t;

  typedef enum logic [1:0] {S_IDLE, S_XFER, S_DRAIN} wmb_state_t;
endpackage
